/* File: rtl/key_matrix_scanner.v */
`timescale 1ns/1ns
`include "key_matrix_scanner_consts.vh"

// Contract
// - clock request stays low whenever the scanner is disabled.
// - request may drop while enabled; row activity raises it again.
// - column count programmable from one to twenty.
// - row count programmable from one to eight.
// - sixteen-entry byte buffer holds detected key codes.
// - buffered keys stay until read; keys found while the buffer is full are dropped.
// - any number of keys; a key on a row hit by an earlier multi-key column is locked out.
// - row samples are glitch filtered and debounced before acceptance.
// - in idle every column output is driven high.
// - idle row transition raises clock request and starts scanning.
// - idle clears row-hit register and key-index counter.
// - row counter wraps at row count, then column counter advances.
// - both counters terminal moves scan to scan-end.
// - key index increments per visited position and identifies the key.
// - modifier keys are matched; other keys go to the buffer.
// - column with two or more hits ORs rows into row-hit register.
// - key on row already hit in earlier column sets ghost status.
// - scan-end rescans if any key was found, else returns idle.
// - returning to idle drops the clock request.
// - full 160-key pass takes about 1.25 ms at 128 kHz.
module key_matrix_scanner #(
   parameter DEPTH    = 16,
   parameter AW       = 4,
   parameter TICK_CYC = `KS_TICK_CYC
) (
   // apb
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // matrix
   input  wire [7:0]  row_in,
   output reg  [19:0] col_out,
   // shared low-power clock
   output reg         clk_req
);
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_SCAN = 3'b010;
   localparam [2:0] ST_END  = 3'b100;
   localparam [31:0] GLITCH = `KS_GLITCH_CYC;
   localparam [31:0] TICK_LAST = TICK_CYC - 1;

   // ---------------------------------------------------------
   // functions
   // ---------------------------------------------------------
   function [19:0] col_sel;
      input [4:0] c;
      begin
         col_sel = 20'h00001 << c;
      end
   endfunction

   function two_plus;
      input [7:0] v;
      integer i;
      reg [3:0] n;
      begin
         n = 4'h0;
         for (i = 0; i < 8; i = i + 1) begin
            n = n + {3'h0, v[i]};
         end
         two_plus = (n >= 4'h2);
      end
   endfunction

   function [4:0] clamp;
      input [4:0] v;
      input [4:0] mx;
      begin
         if (v == 5'h00)
            clamp = 5'h01;
         else if (v > mx)
            clamp = mx;
         else
            clamp = v;
      end
   endfunction

   // ---------------------------------------------------------
   // registers
   // ---------------------------------------------------------
   reg         en_reg;
   reg [4:0]   ncol_reg;
   reg [3:0]   nrow_reg;
   reg [31:0]  mod_reg;
   reg         ghost_reg;
   reg         ovf_reg;
   reg [3:0]   mod_stat_reg;

   reg [7:0]   row_s1;
   reg [7:0]   row_s2;
   reg [7:0]   row_s3;
   reg [7:0]   row_flt;
   reg [6:0]   stab_cnt;
   reg [9:0]   tick_cnt;
   reg         tick;

   reg [2:0]   state;
   reg [2:0]   row_cnt;
   reg [4:0]   col_cnt;
   reg [7:0]   key_idx;
   reg [7:0]   row_hit;
   reg         any_key;
   reg [3:0]   mod_cur;
   reg [159:0] prev_map;
   reg [159:0] down_map;

   reg [7:0]   mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0]  count;

   // ---------------------------------------------------------
   // decode
   // ---------------------------------------------------------
   wire [4:0] ncol_eff = clamp(ncol_reg, 5'h14);
   wire [4:0] nrow_eff = clamp({1'b0, nrow_reg}, 5'h08);
   wire [2:0] row_last = nrow_eff[2:0] - 3'h1;
   wire [4:0] col_last = ncol_eff - 5'h01;
   wire [7:0] row_mask = 8'hFF >> (5'h08 - nrow_eff);

   wire       setup  = psel & ~penable;
   wire       done   = psel & penable & pready;
   wire       wr_ok  = done & pwrite;
   wire       rd_ok  = setup & ~pwrite;

   wire       pressed = row_flt[row_cnt];
   wire       ghost_hit = pressed & row_hit[row_cnt];
   wire       stable_dn = pressed & prev_map[key_idx];
   wire       new_press = stable_dn & ~down_map[key_idx]
                          & ~ghost_hit;
   wire [3:0] mod_hit = {mod_reg[31:24] == key_idx,
                         mod_reg[23:16] == key_idx,
                         mod_reg[15:8]  == key_idx,
                         mod_reg[7:0]   == key_idx};
   wire       is_mod = |mod_hit;
   wire       step   = tick & (state == ST_SCAN);
   wire       push   = step & new_press & ~is_mod;
   wire       full   = (count == DEPTH);
   wire       pop    = rd_ok & (paddr == `KS_OFS_DATA)
                       & (count != 0);
   wire       do_wr  = push & ~full;
   wire       w1c    = wr_ok & (paddr == `KS_OFS_STATUS);

   // ---------------------------------------------------------
   // row synchroniser and glitch filter
   // ---------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         row_s1   <= 8'h00;
         row_s2   <= 8'h00;
         row_s3   <= 8'h00;
         row_flt  <= 8'h00;
         stab_cnt <= 7'h00;
      end else begin
         row_s1 <= row_in;
         row_s2 <= row_s1;
         row_s3 <= row_s2;
         if (row_s2 != row_s3)
            stab_cnt <= 7'h00;
         else if (stab_cnt != GLITCH[6:0])
            stab_cnt <= stab_cnt + 7'h01;
         else
            row_flt <= row_s3;
      end
   end

   // ---------------------------------------------------------
   // 128 khz scan tick
   // ---------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt <= 10'h000;
         tick     <= 1'b0;
      end else if (!clk_req) begin
         tick_cnt <= 10'h000;
         tick     <= 1'b0;
      end else if (tick_cnt == TICK_LAST[9:0]) begin
         tick_cnt <= 10'h000;
         tick     <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 10'h001;
         tick     <= 1'b0;
      end
   end

   // ---------------------------------------------------------
   // scan state machine
   // ---------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state        <= ST_IDLE;
         clk_req      <= 1'b0;
         col_out      <= 20'hFFFFF;
         row_cnt      <= 3'h0;
         col_cnt      <= 5'h00;
         key_idx      <= 8'h00;
         row_hit      <= 8'h00;
         any_key      <= 1'b0;
         mod_cur      <= 4'h0;
         mod_stat_reg <= 4'h0;
         prev_map     <= 160'h0;
         down_map     <= 160'h0;
      end else if (!en_reg) begin
         state   <= ST_IDLE;
         clk_req <= 1'b0;
         col_out <= 20'hFFFFF;
         row_cnt <= 3'h0;
         col_cnt <= 5'h00;
         key_idx <= 8'h00;
         row_hit <= 8'h00;
      end else begin
         case (state)
            ST_IDLE: begin
               col_out  <= 20'hFFFFF;
               row_cnt  <= 3'h0;
               col_cnt  <= 5'h00;
               key_idx  <= 8'h00;
               row_hit  <= 8'h00;
               any_key  <= 1'b0;
               prev_map <= 160'h0;
               down_map <= 160'h0;
               if (row_s2 != row_s3) begin
                  state   <= ST_SCAN;
                  clk_req <= 1'b1;
                  col_out <= col_sel(5'h00);
               end
            end
            ST_SCAN: begin
               if (tick) begin
                  prev_map[key_idx] <= pressed;
                  if (new_press)
                     down_map[key_idx] <= 1'b1;
                  else if (!pressed)
                     down_map[key_idx] <= 1'b0;
                  if (stable_dn)
                     mod_cur <= mod_cur | mod_hit;
                  any_key <= any_key | pressed;
                  key_idx <= key_idx + 8'h01;
                  if (row_cnt == row_last) begin
                     row_cnt <= 3'h0;
                     if (two_plus(row_flt & row_mask))
                        row_hit <= row_hit | (row_flt & row_mask);
                     if (col_cnt == col_last) begin
                        state <= ST_END;
                     end else begin
                        col_cnt <= col_cnt + 5'h01;
                        col_out <= col_sel(col_cnt + 5'h01);
                     end
                  end else begin
                     row_cnt <= row_cnt + 3'h1;
                  end
               end
            end
            ST_END: begin
               if (tick) begin
                  mod_stat_reg <= mod_cur;
                  mod_cur      <= 4'h0;
                  row_cnt      <= 3'h0;
                  col_cnt      <= 5'h00;
                  key_idx      <= 8'h00;
                  row_hit      <= 8'h00;
                  any_key      <= 1'b0;
                  if (any_key) begin
                     state   <= ST_SCAN;
                     col_out <= col_sel(5'h00);
                  end else begin
                     state   <= ST_IDLE;
                     clk_req <= 1'b0;
                     col_out <= 20'hFFFFF;
                  end
               end
            end
            default: begin
               state   <= ST_IDLE;
               clk_req <= 1'b0;
               col_out <= 20'hFFFFF;
            end
         endcase
      end
   end

   // ---------------------------------------------------------
   // key code buffer
   // ---------------------------------------------------------
   always @(posedge pclk) begin
      if (do_wr)
         mem[wr_ptr] <= key_idx;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end else begin
         if (do_wr)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
         if (do_wr && !pop)
            count <= count + 1'b1;
         else if (pop && !do_wr)
            count <= count - 1'b1;
      end
   end

   // ---------------------------------------------------------
   // status flags
   // ---------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ghost_reg <= 1'b0;
         ovf_reg   <= 1'b0;
      end else begin
         if (step && ghost_hit)
            ghost_reg <= 1'b1;
         else if (w1c && pwdata[`KS_ST_GHOST])
            ghost_reg <= 1'b0;
         if (push && full)
            ovf_reg <= 1'b1;
         else if (w1c && pwdata[`KS_ST_OVF])
            ovf_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------
   // apb slave
   // ---------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_reg   <= `KS_RST_EN;
         ncol_reg <= `KS_RST_NCOL;
         nrow_reg <= `KS_RST_NROW;
         mod_reg  <= `KS_RST_MOD;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
         prdata   <= 32'h00000000;
      end else begin
         pready <= setup;
         if (setup) begin
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            case (paddr)
               `KS_OFS_CTRL: begin
                  prdata[`KS_CTRL_EN] <= en_reg;
                  prdata[`KS_CTRL_COL_HI:`KS_CTRL_COL_LO] <= ncol_reg;
                  prdata[`KS_CTRL_ROW_HI:`KS_CTRL_ROW_LO] <= nrow_reg;
               end
               `KS_OFS_STATUS: begin
                  prdata[`KS_ST_CNT_HI:`KS_ST_CNT_LO] <= count;
                  prdata[`KS_ST_GHOST] <= ghost_reg;
                  prdata[`KS_ST_OVF]   <= ovf_reg;
                  prdata[`KS_ST_BUSY]  <= (state != ST_IDLE);
                  prdata[`KS_ST_REQ]   <= clk_req;
                  prdata[`KS_ST_MOD_HI:`KS_ST_MOD_LO] <= mod_stat_reg;
               end
               `KS_OFS_DATA: begin
                  if (count != 0)
                     prdata[7:0] <= mem[rd_ptr];
               end
               `KS_OFS_MOD: begin
                  prdata <= mod_reg;
               end
               default: begin
                  pslverr <= 1'b1;
               end
            endcase
         end
         if (wr_ok) begin
            case (paddr)
               `KS_OFS_CTRL: begin
                  en_reg   <= pwdata[`KS_CTRL_EN];
                  ncol_reg <= pwdata[`KS_CTRL_COL_HI:`KS_CTRL_COL_LO];
                  nrow_reg <= pwdata[`KS_CTRL_ROW_HI:`KS_CTRL_ROW_LO];
               end
               `KS_OFS_MOD: begin
                  mod_reg <= pwdata;
               end
               default: begin
                  mod_reg <= mod_reg;
               end
            endcase
         end
      end
   end
endmodule

/* File: rtl/key_matrix_scanner_consts.vh */
`ifndef KEY_MATRIX_SCANNER_CONSTS_VH
`define KEY_MATRIX_SCANNER_CONSTS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define KS_OFS_CTRL     12'h000
`define KS_OFS_STATUS   12'h004
`define KS_OFS_DATA     12'h008
`define KS_OFS_MOD      12'h00C

// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define KS_CTRL_EN      0
`define KS_CTRL_COL_LO  8
`define KS_CTRL_COL_HI  12
`define KS_CTRL_ROW_LO  16
`define KS_CTRL_ROW_HI  19

// ------------------------------------------------------------
// status fields
// ------------------------------------------------------------
`define KS_ST_CNT_LO    0
`define KS_ST_CNT_HI    4
`define KS_ST_GHOST     8
`define KS_ST_OVF       9
`define KS_ST_BUSY      10
`define KS_ST_REQ       11
`define KS_ST_MOD_LO    12
`define KS_ST_MOD_HI    15

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define KS_RST_EN       1'b0
`define KS_RST_NCOL     5'h14
`define KS_RST_NROW     4'h8
`define KS_RST_MOD      32'hFFFFFFFF

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define KS_PCLK_HZ      100000000
`define KS_PCLK_NS      10
`define KS_LPO_HZ       128000
`define KS_TICK_CYC     (`KS_PCLK_HZ / `KS_LPO_HZ)
`define KS_GLITCH_NS    1000
`define KS_GLITCH_CYC   ((`KS_GLITCH_NS + `KS_PCLK_NS - 1) / `KS_PCLK_NS)

`endif

/* File: bench/key_matrix_scanner_chk.sv */
`timescale 1ns/1ns
module key_matrix_scanner_chk #(
   parameter TICK_CYC = 781
) (
   // apb
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // matrix and clock request
   input wire [7:0]  row_in,
   input wire [19:0] col_out,
   input wire        clk_req
);
   // ----------------------------------------
   // shadow of enable and column dwell count
   // ----------------------------------------
   reg        en_q;
   reg [19:0] col_q;
   integer    dwell;
   wire       acc = psel & penable & pready;
   wire       moved = clk_req && (col_out != col_q);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q  <= 1'b0;
         col_q <= 20'hFFFFF;
         dwell <= 0;
      end else begin
         if (acc && pwrite && paddr == 12'h000)
            en_q <= pwdata[0];
         col_q <= col_out;
         dwell <= (col_out != col_q) ? 0 : dwell + 1;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_req_off_disabled: assert property (!en_q |=> !clk_req)
      else $error("clock request while disabled");
   a_req_wake_row: assert property (en_q && !clk_req &&
      row_in != $past(row_in) |-> ##[1:5] (clk_req || !en_q))
      else $error("row change did not wake scanner");
   a_idle_cols_high: assert property (!clk_req |-> col_out == 20'hFFFFF)
      else $error("columns not all high in idle");
   a_wake_col_zero: assert property ($rose(clk_req) |-> col_out == 20'h1)
      else $error("scan did not start at column zero");
   a_col_step_one: assert property (moved && $past(clk_req) |->
      col_out == {col_q[18:0], 1'b0} || col_out == 20'h1)
      else $error("column did not advance by one");
   a_col_dwell_tick: assert property (moved && $past(clk_req) |->
      dwell >= TICK_CYC - 2)
      else $error("column left before one tick");
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_has_cause: assert property (pready |->
      $past(psel) && !$past(penable))
      else $error("ready without setup");
   a_err_unmapped: assert property (acc && paddr > 12'h00C |->
      pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   a_err_mapped: assert property (acc && paddr <= 12'h00C &&
      paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("mapped access refused");
   c_wake: cover property ($rose(clk_req));
   c_sleep: cover property ($fell(clk_req));
   c_slverr: cover property (acc && pslverr);
   c_pop: cover property (acc && !pwrite && paddr == 12'h008);
endmodule
bind key_matrix_scanner key_matrix_scanner_chk #(
   .TICK_CYC(TICK_CYC)
) key_matrix_scanner_chk_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .row_in(row_in),
   .col_out(col_out), .clk_req(clk_req)
);

/* File: bench/key_matrix_model.sv */
`timescale 1ns/1ns
module key_matrix_model (
   // columns from scanner, held keys
   input  wire [19:0]  col_out,
   input  wire [159:0] keys,
   // rows, pulled low when no closed switch connects them
   output reg  [7:0]   row_in
);
   integer c, r;
   always @* begin
      row_in = 8'h00;
      for (c = 0; c < 20; c = c + 1) begin
         for (r = 0; r < 8; r = r + 1) begin
            if (col_out[c] && keys[c*8+r])
               row_in[r] = 1'b1;
         end
      end
   end
endmodule

/* File: bench/key_matrix_scanner_tb_top.sv */
`timescale 1ns/1ns
`include "key_matrix_scanner_consts.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
   $display("unexpected %0t: got %h exp %h", $time, a, b); end end
module key_matrix_scanner_tb_top;
   localparam TICK = 200;
   reg          pclk = 1'b0;
   reg          presetn = 1'b0;
   reg          psel = 1'b0;
   reg          penable = 1'b0;
   reg          pwrite = 1'b0;
   reg  [11:0]  paddr = 12'h000;
   reg  [31:0]  pwdata = 32'h0;
   reg  [159:0] keys = 160'h0;
   wire [31:0]  prdata;
   wire         pready;
   wire         pslverr;
   wire [7:0]   row_in;
   wire [19:0]  col_out;
   wire         clk_req;
   reg  [31:0]  rd;
   reg          err;
   integer      fails = 0;
   integer      cmp_count = 0;
   integer      seed = 91;
   integer      i, k, r, c;
   integer      exp_q[$];
   key_matrix_scanner #(.TICK_CYC(TICK)) key_matrix_scanner_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .row_in(row_in),
      .col_out(col_out), .clk_req(clk_req));
   key_matrix_model key_matrix_model_inst (
      .col_out(col_out), .keys(keys), .row_in(row_in));
   // ----------------------------------------
   // bus and wait tasks
   // ----------------------------------------
   task finish_test;
      begin
         $display("mismatches %0d compares %0d", fails, cmp_count);
         if (fails == 0 && cmp_count > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task apb(input [11:0] a, input w, input [31:0] d);
      integer n;
      begin
         n = 0;
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n = n + 1;
         end
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         if (n == 20) begin
            fails++;
            finish_test;
         end
      end
   endtask
   task poll(input [4:0] n);
      integer j;
      begin
         j = 0;
         apb(`KS_OFS_STATUS, 1'b0, 32'h0);
         while (rd[4:0] !== n && j < 150) begin
            repeat (100) @(posedge pclk);
            apb(`KS_OFS_STATUS, 1'b0, 32'h0);
            j = j + 1;
         end
         if (rd[4:0] !== n) begin
            fails++;
            finish_test;
         end
      end
   endtask
   task idle_wait;
      integer j;
      begin
         j = 0;
         while (clk_req !== 1'b0 && j < 20000) begin
            @(posedge pclk);
            j = j + 1;
         end
         if (clk_req !== 1'b0) begin
            fails++;
            finish_test;
         end
      end
   endtask
   task pop;
      begin
         apb(`KS_OFS_DATA, 1'b0, 32'h0);
         k = (exp_q.size() > 0) ? exp_q.pop_front() : 0;
         `CHK(rd[7:0], k[7:0])
      end
   endtask
   // ----------------------------------------
   // stimulus
   // ----------------------------------------
   initial begin
      forever #5 pclk = ~pclk;
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(`KS_OFS_CTRL, 1'b0, 32'h0);
      `CHK(rd, 32'h00081400)
      apb(`KS_OFS_MOD, 1'b0, 32'h0);
      `CHK(rd, 32'hFFFFFFFF)
      apb(`KS_OFS_STATUS, 1'b0, 32'h0);
      `CHK(rd, 32'h0)
      apb(12'h010, 1'b1, 32'h1);
      `CHK(err, 1'b1)
      keys[0] <= 1'b1;
      repeat (300) @(posedge pclk);
      `CHK(clk_req, 1'b0)
      keys <= 160'h0;
      apb(`KS_OFS_CTRL, 1'b1, 32'h000F0000);
      apb(`KS_OFS_CTRL, 1'b0, 32'h0);
      `CHK(rd, 32'h000F0000)
      apb(`KS_OFS_CTRL, 1'b1, 32'h00001F00);
      apb(`KS_OFS_CTRL, 1'b0, 32'h0);
      `CHK(rd, 32'h00001F00)
      apb(`KS_OFS_CTRL, 1'b1, 32'h00020301);
      r = {$random(seed)} % 2;
      c = {$random(seed)} % 3;
      keys[c*8+r] <= 1'b1;
      exp_q.push_back(c * 2 + r);
      poll(5'd1);
      `CHK(rd[11:10], 2'b11)
      pop;
      keys <= 160'h0;
      idle_wait;
      `CHK(col_out, 20'hFFFFF)
      keys[0] <= 1'b1;
      keys[1] <= 1'b1;
      keys[8] <= 1'b1;
      exp_q.push_back(0);
      exp_q.push_back(1);
      poll(5'd2);
      `CHK(rd[8], 1'b1)
      pop;
      pop;
      keys <= 160'h0;
      idle_wait;
      apb(`KS_OFS_STATUS, 1'b1, 32'h00000100);
      apb(`KS_OFS_STATUS, 1'b0, 32'h0);
      `CHK(rd, 32'h0)
      apb(`KS_OFS_MOD, 1'b1, 32'hFFFFFF02);
      keys[8] <= 1'b1;
      keys[16] <= 1'b1;
      exp_q.push_back(4);
      repeat (15 * TICK) @(posedge pclk);
      apb(`KS_OFS_STATUS, 1'b0, 32'h0);
      `CHK(rd[15:12], 4'h1)
      `CHK(rd[4:0], 5'd1)
      pop;
      keys <= 160'h0;
      idle_wait;
      apb(`KS_OFS_MOD, 1'b1, 32'hFFFFFFFF);
      apb(`KS_OFS_CTRL, 1'b1, 32'h00001F01);
      for (i = 0; i < 17; i = i + 1)
         keys[i*8] <= 1'b1;
      for (i = 0; i < 16; i = i + 1)
         exp_q.push_back(i);
      poll(5'd16);
      repeat (3 * TICK) @(posedge pclk);
      apb(`KS_OFS_STATUS, 1'b0, 32'h0);
      `CHK(rd[9], 1'b1)
      `CHK(rd[4:0], 5'd16)
      keys <= 160'h0;
      idle_wait;
      apb(`KS_OFS_STATUS, 1'b0, 32'h0);
      `CHK(rd[4:0], 5'd16)
      for (i = 0; i < 17; i = i + 1)
         pop;
      apb(`KS_OFS_STATUS, 1'b1, 32'h00000200);
      apb(`KS_OFS_STATUS, 1'b0, 32'h0);
      `CHK(rd, 32'h0)
      keys[0] <= 1'b1;
      repeat (50) @(posedge pclk);
      `CHK(clk_req, 1'b1)
      apb(`KS_OFS_CTRL, 1'b1, 32'h00011400);
      repeat (2) @(posedge pclk);
      `CHK(clk_req, 1'b0)
      `CHK(col_out, 20'hFFFFF)
      finish_test;
   end
endmodule
